// ### rti_pkg.sv
`default_nettype none
package rti_pkg;
  localparam int unsigned OP_W = 10;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned SP_W = 3;
  localparam int unsigned FILE_W = 2;
  localparam int unsigned EXT_W = 3;
  localparam int unsigned PAIR_W = 8;
  // Opcodes of the decoded transfer group
  localparam logic [9:0] OP_READ_COLUMN = 10'h052;
  localparam logic [9:0] OP_READ_ROW = 10'h01F;
  localparam logic [9:0] OP_READ_FILE = 10'h053;
  localparam logic [9:0] OP_WRITE_HIGH = 10'h00E;
  localparam logic [9:0] OP_WRITE_EXTRA = 10'h029;
  localparam logic [9:0] OP_READ_STACK = 10'h050;
  localparam logic [9:0] OP_READ_CLOCK_MODE = 10'h2CA;
  localparam logic [9:0] OP_READ_PULL_FIRST = 10'h257;
  localparam logic [9:0] OP_READ_PULL_SECOND = 10'h25E;
  localparam logic [9:0] OP_READ_PULL_THIRD = 10'h25F;
  localparam logic [9:0] OP_READ_IRQ_ONE = 10'h054;
  localparam logic [9:0] OP_READ_IRQ_TWO = 10'h055;
  localparam logic [9:0] OP_READ_TIMER_ONE = 10'h24B;
  localparam logic [9:0] OP_READ_TIMER_TWO = 10'h24C;
  localparam logic [9:0] OP_READ_TIMER_THREE = 10'h24D;
  localparam logic [9:0] OP_READ_TIMER_FIVE = 10'h24F;
  localparam logic [9:0] OP_WRITE_PAIR = 10'h01A;
  localparam logic [9:0] OP_WRITE_PORT_A = 10'h22B;
  localparam logic [9:0] OP_WRITE_PORT_B = 10'h22C;
  localparam logic [9:0] OP_WRITE_IRQ_AUX = 10'h211;
  localparam logic [9:0] OP_WRITE_WAKE_FIRST = 10'h21B;
  localparam logic [9:0] OP_WRITE_WAKE_SECOND = 10'h214;
  localparam logic [9:0] OP_WRITE_WAKE_THIRD = 10'h215;
  // Reset values
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [2:0] RST_EXT = 3'h0;
  localparam logic [7:0] RST_PAIR = 8'h00;
endpackage : rti_pkg
`default_nettype wire

// ### rti_exec.sv
`default_nettype none
module rti_exec (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic op_valid_in,
  input wire logic [9:0] op_in,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] column_ptr_in,
  input wire logic [3:0] row_ptr_in,
  input wire logic [1:0] file_ptr_in,
  input wire logic [2:0] stack_ptr_in,
  input wire logic [3:0] clock_mode_reg_in,
  input wire logic [3:0] irq_ctl_one_in,
  input wire logic [3:0] irq_ctl_two_in,
  input wire logic [3:0] timer_ctl_one_in,
  input wire logic [3:0] timer_ctl_two_in,
  input wire logic [3:0] timer_ctl_three_in,
  input wire logic [3:0] timer_ctl_five_in,
  input wire logic [3:0] pull_up_ctl_first_in,
  input wire logic [3:0] pull_up_ctl_second_in,
  input wire logic [3:0] pull_up_ctl_third_in,
  output logic acc_we_out,
  output logic [3:0] acc_out,
  output logic decoded_out,
  output logic skip_out,
  output logic carry_we_out,
  output logic [3:0] high_operand_out,
  output logic [2:0] extra_ptr_out,
  output logic [7:0] pair_out,
  output logic [3:0] port_ctl_a_out,
  output logic [3:0] port_ctl_b_out,
  output logic [3:0] irq_ctl_aux_out,
  output logic [3:0] wake_ctl_first_out,
  output logic [3:0] wake_ctl_second_out,
  output logic [3:0] wake_ctl_third_out
);
  logic go;
  logic is_rd_col, is_rd_row, is_rd_file, is_rd_stack, is_rd_clk;
  logic is_rd_pu0, is_rd_pu1, is_rd_pu2, is_rd_v1, is_rd_v2;
  logic is_rd_w1, is_rd_w2, is_rd_w3, is_rd_w5;
  logic is_wr_high, is_wr_ext, is_wr_pair, is_wr_pa, is_wr_pb;
  logic is_wr_aux, is_wr_k0, is_wr_k1, is_wr_k2;
  logic any_read, any_write;
  logic [3:0] read_val;
  logic [3:0] acc_q, acc_d;
  logic acc_we_q;
  logic [3:0] high_q, pa_q, pb_q, aux_q, k0_q, k1_q, k2_q;
  logic [2:0] ext_q;
  logic [7:0] pair_q;

  // Decode is gated here so a frozen clock enable never commits a transfer
  assign go = op_valid_in & clk_en_in;
  assign is_rd_col = go & (op_in == rti_pkg::OP_READ_COLUMN);
  assign is_rd_row = go & (op_in == rti_pkg::OP_READ_ROW);
  assign is_rd_file = go & (op_in == rti_pkg::OP_READ_FILE);
  assign is_rd_stack = go & (op_in == rti_pkg::OP_READ_STACK);
  assign is_rd_clk = go & (op_in == rti_pkg::OP_READ_CLOCK_MODE);
  assign is_rd_pu0 = go & (op_in == rti_pkg::OP_READ_PULL_FIRST);
  assign is_rd_pu1 = go & (op_in == rti_pkg::OP_READ_PULL_SECOND);
  assign is_rd_pu2 = go & (op_in == rti_pkg::OP_READ_PULL_THIRD);
  assign is_rd_v1 = go & (op_in == rti_pkg::OP_READ_IRQ_ONE);
  assign is_rd_v2 = go & (op_in == rti_pkg::OP_READ_IRQ_TWO);
  assign is_rd_w1 = go & (op_in == rti_pkg::OP_READ_TIMER_ONE);
  assign is_rd_w2 = go & (op_in == rti_pkg::OP_READ_TIMER_TWO);
  assign is_rd_w3 = go & (op_in == rti_pkg::OP_READ_TIMER_THREE);
  assign is_rd_w5 = go & (op_in == rti_pkg::OP_READ_TIMER_FIVE);
  assign is_wr_high = go & (op_in == rti_pkg::OP_WRITE_HIGH);
  assign is_wr_ext = go & (op_in == rti_pkg::OP_WRITE_EXTRA);
  assign is_wr_pair = go & (op_in == rti_pkg::OP_WRITE_PAIR);
  assign is_wr_pa = go & (op_in == rti_pkg::OP_WRITE_PORT_A);
  assign is_wr_pb = go & (op_in == rti_pkg::OP_WRITE_PORT_B);
  assign is_wr_aux = go & (op_in == rti_pkg::OP_WRITE_IRQ_AUX);
  assign is_wr_k0 = go & (op_in == rti_pkg::OP_WRITE_WAKE_FIRST);
  assign is_wr_k1 = go & (op_in == rti_pkg::OP_WRITE_WAKE_SECOND);
  assign is_wr_k2 = go & (op_in == rti_pkg::OP_WRITE_WAKE_THIRD);

  assign any_read = is_rd_col | is_rd_row | is_rd_file | is_rd_stack | is_rd_clk |
                    is_rd_pu0 | is_rd_pu1 | is_rd_pu2 | is_rd_v1 | is_rd_v2 |
                    is_rd_w1 | is_rd_w2 | is_rd_w3 | is_rd_w5;
  assign any_write = is_wr_high | is_wr_ext | is_wr_pair | is_wr_pa | is_wr_pb |
                     is_wr_aux | is_wr_k0 | is_wr_k1 | is_wr_k2;

  // One-hot select; at most one term is live per cycle
  assign read_val = ({4{is_rd_col}} & column_ptr_in) |
                    ({4{is_rd_row}} & row_ptr_in) |
                    ({4{is_rd_file}} & {2'h0, file_ptr_in}) |
                    ({4{is_rd_stack}} & {1'h0, stack_ptr_in}) |
                    ({4{is_rd_clk}} & clock_mode_reg_in) |
                    ({4{is_rd_pu0}} & pull_up_ctl_first_in) |
                    ({4{is_rd_pu1}} & pull_up_ctl_second_in) |
                    ({4{is_rd_pu2}} & pull_up_ctl_third_in) |
                    ({4{is_rd_v1}} & irq_ctl_one_in) |
                    ({4{is_rd_v2}} & irq_ctl_two_in) |
                    ({4{is_rd_w1}} & timer_ctl_one_in) |
                    ({4{is_rd_w2}} & timer_ctl_two_in) |
                    ({4{is_rd_w3}} & timer_ctl_three_in) |
                    ({4{is_rd_w5}} & timer_ctl_five_in);
  assign acc_d = any_read ? read_val : acc_q;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      acc_q <= rti_pkg::RST_NIB;
      acc_we_q <= 1'b0;
    end else if (clk_en_in) begin
      acc_q <= acc_d;
      acc_we_q <= any_read;
    end
  end

  // Write targets; registers clear to zero at reset
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      high_q <= rti_pkg::RST_NIB;
      ext_q <= rti_pkg::RST_EXT;
      pair_q <= rti_pkg::RST_PAIR;
      pa_q <= rti_pkg::RST_NIB;
      pb_q <= rti_pkg::RST_NIB;
      aux_q <= rti_pkg::RST_NIB;
      k0_q <= rti_pkg::RST_NIB;
      k1_q <= rti_pkg::RST_NIB;
      k2_q <= rti_pkg::RST_NIB;
    end else if (clk_en_in) begin
      if (is_wr_high) high_q <= acc_in;
      if (is_wr_ext) ext_q <= acc_in[2:0];
      if (is_wr_pair) pair_q <= {high_q, acc_in};
      if (is_wr_pa) pa_q <= acc_in;
      if (is_wr_pb) pb_q <= acc_in;
      if (is_wr_aux) aux_q <= acc_in;
      if (is_wr_k0) k0_q <= acc_in;
      if (is_wr_k1) k1_q <= acc_in;
      if (is_wr_k2) k2_q <= acc_in;
    end
  end

  assign acc_we_out = acc_we_q;
  assign acc_out = acc_q;
  assign decoded_out = any_read | any_write;
  assign skip_out = 1'b0;
  assign carry_we_out = 1'b0;
  assign high_operand_out = high_q;
  assign extra_ptr_out = ext_q;
  assign pair_out = pair_q;
  assign port_ctl_a_out = pa_q;
  assign port_ctl_b_out = pb_q;
  assign irq_ctl_aux_out = aux_q;
  assign wake_ctl_first_out = k0_q;
  assign wake_ctl_second_out = k1_q;
  assign wake_ctl_third_out = k2_q;

  property p_col;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_col |=> (acc_out == $past(column_ptr_in)) && acc_we_out;
  endproperty
  a_col: assert property (p_col) else $error("column read wrong");
  property p_row;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_row |=> acc_out == $past(row_ptr_in);
  endproperty
  a_row: assert property (p_row) else $error("row read wrong");
  property p_file;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_file |=> acc_out == {2'h0, $past(file_ptr_in)};
  endproperty
  a_file: assert property (p_file) else $error("file read wrong");
  property p_high;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_high |=> high_operand_out == $past(acc_in);
  endproperty
  a_high: assert property (p_high) else $error("high write wrong");
  property p_ext;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_ext |=> extra_ptr_out == $past(acc_in[2:0]);
  endproperty
  a_ext: assert property (p_ext) else $error("extra write wrong");
  property p_stack;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_stack |=> acc_out == {1'h0, $past(stack_ptr_in)};
  endproperty
  a_stack: assert property (p_stack) else $error("stack read wrong");
  property p_pair;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_pair |=> pair_out == {$past(high_operand_out), $past(acc_in)};
  endproperty
  a_pair: assert property (p_pair) else $error("pair write wrong");
  property p_k1;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_k1 |=> (wake_ctl_second_out == $past(acc_in)) && $stable(wake_ctl_first_out)
        && $stable(wake_ctl_third_out);
  endproperty
  a_k1: assert property (p_k1) else $error("wake second write wrong");
  property p_hold;
    @(posedge clk_in) disable iff (!resetn_in)
      !any_read && clk_en_in |=> $stable(acc_out) && !acc_we_out;
  endproperty
  a_hold: assert property (p_hold) else $error("accumulator changed");

  // Reads of registers that other parts of the core own
  property p_clk;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_clk |=> (acc_out == $past(clock_mode_reg_in)) && acc_we_out;
  endproperty
  a_clk: assert property (p_clk) else $error("clock mode read wrong");

  property p_pu_first;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_pu0 |=> (acc_out == $past(pull_up_ctl_first_in)) && acc_we_out;
  endproperty
  a_pu_first: assert property (p_pu_first) else $error("pull-up first read wrong");

  property p_pu_second;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_pu1 |=> (acc_out == $past(pull_up_ctl_second_in)) && acc_we_out;
  endproperty
  a_pu_second: assert property (p_pu_second) else $error("pull-up second read wrong");

  property p_pu_third;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_pu2 |=> (acc_out == $past(pull_up_ctl_third_in)) && acc_we_out;
  endproperty
  a_pu_third: assert property (p_pu_third) else $error("pull-up third read wrong");

  property p_irq_one;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_v1 |=> (acc_out == $past(irq_ctl_one_in)) && acc_we_out;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq one read wrong");

  property p_irq_two;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_v2 |=> (acc_out == $past(irq_ctl_two_in)) && acc_we_out;
  endproperty
  a_irq_two: assert property (p_irq_two) else $error("irq two read wrong");

  property p_tmr_one;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_w1 |=> (acc_out == $past(timer_ctl_one_in)) && acc_we_out;
  endproperty
  a_tmr_one: assert property (p_tmr_one) else $error("timer one read wrong");

  property p_tmr_two;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_w2 |=> (acc_out == $past(timer_ctl_two_in)) && acc_we_out;
  endproperty
  a_tmr_two: assert property (p_tmr_two) else $error("timer two read wrong");

  property p_tmr_three;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_w3 |=> (acc_out == $past(timer_ctl_three_in)) && acc_we_out;
  endproperty
  a_tmr_three: assert property (p_tmr_three) else $error("timer three read wrong");

  property p_tmr_five;
    @(posedge clk_in) disable iff (!resetn_in)
      is_rd_w5 |=> (acc_out == $past(timer_ctl_five_in)) && acc_we_out;
  endproperty
  a_tmr_five: assert property (p_tmr_five) else $error("timer five read wrong");

  // Writes into registers held in this block
  property p_port_a;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_pa |=> port_ctl_a_out == $past(acc_in);
  endproperty
  a_port_a: assert property (p_port_a) else $error("port structure a write wrong");

  property p_port_b;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_pb |=> port_ctl_b_out == $past(acc_in);
  endproperty
  a_port_b: assert property (p_port_b) else $error("port structure b write wrong");

  property p_aux;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_aux |=> irq_ctl_aux_out == $past(acc_in);
  endproperty
  a_aux: assert property (p_aux) else $error("aux irq write wrong");

  property p_k0;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_k0 |=> (wake_ctl_first_out == $past(acc_in)) && $stable(wake_ctl_second_out)
        && $stable(wake_ctl_third_out);
  endproperty
  a_k0: assert property (p_k0) else $error("wake first write wrong");

  property p_k2;
    @(posedge clk_in) disable iff (!resetn_in)
      is_wr_k2 |=> (wake_ctl_third_out == $past(acc_in)) && $stable(wake_ctl_first_out)
        && $stable(wake_ctl_second_out);
  endproperty
  a_k2: assert property (p_k2) else $error("wake third write wrong");

  // No disable here, so the cleared state itself is covered
  property p_reset;
    @(posedge clk_in)
      !resetn_in |=> (acc_out == rti_pkg::RST_NIB) && !acc_we_out
        && (high_operand_out == rti_pkg::RST_NIB) && (extra_ptr_out == rti_pkg::RST_EXT)
        && (pair_out == rti_pkg::RST_PAIR) && (irq_ctl_aux_out == rti_pkg::RST_NIB)
        && (port_ctl_a_out == rti_pkg::RST_NIB) && (port_ctl_b_out == rti_pkg::RST_NIB)
        && (wake_ctl_first_out == rti_pkg::RST_NIB) && (wake_ctl_second_out == rti_pkg::RST_NIB)
        && (wake_ctl_third_out == rti_pkg::RST_NIB);
  endproperty
  a_reset: assert property (p_reset) else $error("state not cleared by reset");

  property p_freeze;
    @(posedge clk_in) disable iff (!resetn_in)
      !clk_en_in |=> $stable(acc_out) && $stable(acc_we_out) && $stable(high_operand_out)
        && $stable(pair_out) && $stable(extra_ptr_out) && $stable(wake_ctl_second_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while stalled");

  property p_foreign;
    @(posedge clk_in) disable iff (!resetn_in)
      op_valid_in && clk_en_in && !decoded_out |=> !acc_we_out && $stable(acc_out)
        && $stable(high_operand_out) && $stable(pair_out) && $stable(extra_ptr_out);
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign opcode changed state");

  property p_high_keep;
    @(posedge clk_in) disable iff (!resetn_in)
      !is_wr_high |=> $stable(high_operand_out);
  endproperty
  a_high_keep: assert property (p_high_keep) else $error("high operand changed");

  property p_pair_keep;
    @(posedge clk_in) disable iff (!resetn_in)
      !is_wr_pair |=> $stable(pair_out);
  endproperty
  a_pair_keep: assert property (p_pair_keep) else $error("pair register changed");
endmodule : rti_exec
`default_nettype wire

// ### tb_register_transfer_instructions.sv
`default_nettype none
module tb_register_transfer_instructions;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, resetn_in, clk_en_in, op_valid_in, acc_we_out, decoded_out, skip_out, carry_we_out;
  logic [9:0] op_in;
  logic [3:0] acc_in, column_ptr_in, row_ptr_in, clock_mode_reg_in, irq_ctl_one_in, irq_ctl_two_in;
  logic [3:0] timer_ctl_one_in, timer_ctl_two_in, timer_ctl_three_in, timer_ctl_five_in;
  logic [1:0] file_ptr_in;
  logic [2:0] stack_ptr_in, extra_ptr_out;
  logic [7:0] pair_out;
  logic [3:0] acc_out, high_operand_out, port_ctl_a_out, port_ctl_b_out, irq_ctl_aux_out;
  logic [3:0] pull_up_ctl_first_in, pull_up_ctl_second_in, pull_up_ctl_third_in;
  logic [3:0] wake_ctl_first_out, wake_ctl_second_out, wake_ctl_third_out;
  int mismatches = 0;
  int tests_run = 0;

  rti_exec u_rti_exec (.clk_in, .resetn_in, .clk_en_in, .op_valid_in, .op_in, .acc_in,
    .column_ptr_in, .row_ptr_in, .file_ptr_in, .stack_ptr_in, .clock_mode_reg_in,
    .irq_ctl_one_in, .irq_ctl_two_in, .timer_ctl_one_in, .timer_ctl_two_in,
    .timer_ctl_three_in, .timer_ctl_five_in, .acc_we_out, .acc_out, .decoded_out, .skip_out,
    .carry_we_out, .high_operand_out, .extra_ptr_out, .pair_out, .pull_up_ctl_first_in,
    .pull_up_ctl_second_in, .pull_up_ctl_third_in, .port_ctl_a_out, .port_ctl_b_out,
    .irq_ctl_aux_out, .wake_ctl_first_out, .wake_ctl_second_out, .wake_ctl_third_out);

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Valid stays up across back-to-back calls; idle drops it and lets one edge pass
  task automatic issue(input logic [9:0] op, input logic [3:0] a, input logic dec);
    op_in = op;
    acc_in = a;
    op_valid_in = 1'b1;
    #5;
    if (clk_en_in) chk(decoded_out, dec);
    @(posedge clk_in);
    #2;
  endtask : issue

  task automatic idle();
    op_valid_in = 1'b0;
    @(posedge clk_in);
    #2;
  endtask : idle

  // Accumulator driven to all ones so a read that leaks it shows up
  task automatic rd(input logic [9:0] op, input logic [3:0] exp);
    issue(op, 4'hF, 1'b1);
    chk(acc_out, exp);
    chk(acc_we_out, 1'h1);
    chk(skip_out, 1'h0);
    chk(carry_we_out, 1'h0);
  endtask : rd

  task automatic t_zero();
    chk(acc_out, 4'h0);
    chk(acc_we_out, 1'h0);
    chk(high_operand_out, 4'h0);
    chk(extra_ptr_out, 3'h0);
    chk(pair_out, 8'h00);
    chk({port_ctl_a_out, port_ctl_b_out}, 8'h00);
    chk({irq_ctl_aux_out, wake_ctl_first_out}, 8'h00);
    chk({wake_ctl_second_out, wake_ctl_third_out}, 8'h00);
    chk(decoded_out, 1'h0);
    chk({skip_out, carry_we_out}, 2'h0);
  endtask : t_zero

  task automatic t_reads();
    rd(rti_pkg::OP_READ_COLUMN, 4'hA);
    rd(rti_pkg::OP_READ_ROW, 4'h5);
    rd(rti_pkg::OP_READ_FILE, 4'h2);
    rd(rti_pkg::OP_READ_STACK, 4'h7);
    rd(rti_pkg::OP_READ_CLOCK_MODE, 4'h9);
    rd(rti_pkg::OP_READ_PULL_FIRST, 4'h4);
    rd(rti_pkg::OP_READ_PULL_SECOND, 4'h6);
    rd(rti_pkg::OP_READ_PULL_THIRD, 4'h8);
    rd(rti_pkg::OP_READ_IRQ_ONE, 4'hC);
    rd(rti_pkg::OP_READ_IRQ_TWO, 4'h3);
    rd(rti_pkg::OP_READ_TIMER_ONE, 4'hE);
    rd(rti_pkg::OP_READ_TIMER_TWO, 4'h1);
    rd(rti_pkg::OP_READ_TIMER_THREE, 4'hB);
    rd(rti_pkg::OP_READ_TIMER_FIVE, 4'hD);
    idle();
    chk(acc_we_out, 1'h0);
    chk({acc_out, high_operand_out}, 8'hD0);
  endtask : t_reads

  task automatic t_writes();
    issue(rti_pkg::OP_WRITE_HIGH, 4'h6, 1'b1);
    chk(high_operand_out, 4'h6);
    issue(rti_pkg::OP_WRITE_PAIR, 4'h9, 1'b1);
    chk(pair_out, 8'h69);
    issue(rti_pkg::OP_WRITE_EXTRA, 4'hD, 1'b1);
    chk(extra_ptr_out, 3'h5);
    issue(rti_pkg::OP_WRITE_PORT_A, 4'h1, 1'b1);
    issue(rti_pkg::OP_WRITE_PORT_B, 4'h2, 1'b1);
    chk({port_ctl_a_out, port_ctl_b_out}, 8'h12);
    issue(rti_pkg::OP_WRITE_IRQ_AUX, 4'h3, 1'b1);
    chk(irq_ctl_aux_out, 4'h3);
    issue(rti_pkg::OP_WRITE_WAKE_SECOND, 4'h8, 1'b1);
    chk({wake_ctl_first_out, wake_ctl_second_out, wake_ctl_third_out}, 12'h080);
    issue(rti_pkg::OP_WRITE_WAKE_FIRST, 4'h4, 1'b1);
    issue(rti_pkg::OP_WRITE_WAKE_THIRD, 4'hC, 1'b1);
    chk({wake_ctl_first_out, wake_ctl_second_out, wake_ctl_third_out}, 12'h48C);
    chk({acc_we_out, acc_out, high_operand_out}, 9'h0D6);
    chk({pair_out, extra_ptr_out}, 11'h34D);
  endtask : t_writes

  // Stalled cycles and foreign opcodes must leave the accumulator, its write enable and the high operand untouched
  task automatic t_refused();
    clk_en_in = 1'b0;
    issue(rti_pkg::OP_WRITE_HIGH, 4'h1, 1'b1);
    issue(rti_pkg::OP_READ_ROW, 4'h0, 1'b1);
    chk({acc_we_out, acc_out, high_operand_out}, 9'h0D6);
    clk_en_in = 1'b1;
    issue(10'h3FF, 4'h7, 1'b0);
    chk({acc_we_out, acc_out, high_operand_out}, 9'h0D6);
    idle();
  endtask : t_refused

  initial begin
    resetn_in = 1'b0;
    clk_en_in = 1'b1;
    op_valid_in = 1'b0;
    op_in = 10'h000;
    acc_in = 4'h0;
    column_ptr_in = 4'hA;
    row_ptr_in = 4'h5;
    file_ptr_in = 2'h2;
    stack_ptr_in = 3'h7;
    clock_mode_reg_in = 4'h9;
    irq_ctl_one_in = 4'hC;
    irq_ctl_two_in = 4'h3;
    timer_ctl_one_in = 4'hE;
    timer_ctl_two_in = 4'h1;
    timer_ctl_three_in = 4'hB;
    timer_ctl_five_in = 4'hD;
    pull_up_ctl_first_in = 4'h4;
    pull_up_ctl_second_in = 4'h6;
    pull_up_ctl_third_in = 4'h8;
    repeat (20) @(posedge clk_in);
    #2;
    resetn_in = 1'b1;
    t_zero();
    t_reads();
    t_writes();
    t_refused();
    resetn_in = 1'b0;
    @(posedge clk_in);
    #2;
    resetn_in = 1'b1;
    t_zero();
    tally_and_finish();
  end
endmodule : tb_register_transfer_instructions
`default_nettype wire
